//--- core/epc_top.sv
// eprom programming control: loader pin decode, programming register,
// option word latch, counter and indicator drive
// assumes a classic wishbone master on core_clk and an array beside it
// How it works
// - boot mode samples three pins for loader function
// - mode pins 11 eprom_program_control/verify, 10 verify, 00 dump
// - mode 01 with sync 0 gate, 1 drain
// - drive program and verify indicators in boot
// - provide clock and reset to external counter
// - extra port pin gives upper source address
// - programming register, reset zero, bit1 reads zero
// - special bits writable and readable only in special
// - option latch mapped when decode set, io on
// - test selects act only with test enable
// - dual-byte mode ignores address bit four
// - latch blocks reads and captures array writes
// - power bit switches programming power on array
// - power sets only when latch already set
// - option word captured when reset releases
// - option bits drive pullups, irq sense, watchdog
// - erased option bits leave pullups disabled
// - watchdog option enables watchdog timer outside boot mode
// - irq option selects edge-and-level sensitivity
`timescale 1ns/1ps
module epc_top
	import epc_pkg::*;
#(
	parameter int PULSE_LIMIT = PULSE_MAX_CYCLES,
	parameter int ARRAY_AW = 13
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [15:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	input wire logic bootMode,
	input wire logic testMode,
	input wire logic ioDecodeOff,
	input wire logic bootSyncPin,
	input wire logic modeSelectLowPin,
	input wire logic modeSelectHighPin,
	input wire logic [7:0] optionWordIn,
	input wire logic arrayWrStb,
	input wire logic [ARRAY_AW-1:0] arrayAddr,
	input wire logic [7:0] arrayWrData,
	output logic arrayReadEn,
	output logic [ARRAY_AW-1:0] progAddr,
	output logic [7:0] progData,
	output logic progAddrBit4Ignore,
	output logic programPowerOn,
	output logic [1:0] testSelect,
	output logic programIndicatorPin,
	output logic programIndicatorOe,
	output logic verifyIndicatorPin,
	output logic verifyIndicatorOe,
	output logic counterClk,
	output logic counterRst,
	output logic upperAddrLine,
	output logic [7:0] portCPullup,
	output logic irqEdgeLevel,
	output logic watchdogEnable
);

	initial begin
		if (PULSE_LIMIT < 1)
			$error("PULSE_LIMIT must be at least one cycle");
		if (ARRAY_AW <= DUAL_BYTE_ADDR_BIT)
			$error("ARRAY_AW too narrow for dual-byte bit");
	end

	logic [2:0] pinMeta_r;
	logic [2:0] pinSync_r;
	logic [1:0] sampleCnt_r;
	logic sampled_r;
	epc_function_type func_r;
	epc_function_type func_nxt;
	logic [7:0] eprom_program_control_r;
	logic [7:0] eprom_program_control_nxt;
	logic [7:0] ldr_r;
	logic [7:0] opt_r;
	logic optDone_r;
	logic [31:0] pulseCnt_r;
	logic special;
	logic optMapped;
	logic req;
	logic wrEn;
	logic [13:0] idx;
	logic [31:0] rdData;

	assign special = bootMode | testMode;
	assign req = wbCyc & wbStb & ~wbAck;
	assign idx = wbAdr[15:2];
	assign wrEn = req & wbWe & wbSel[0];
	assign optMapped = eprom_program_control_r[EPROM_PROGRAM_CONTROL_OPT_DECODE] & ~ioDecodeOff;

	// pin synchroniser, first stage read only by second
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pinMeta_r <= 3'h0;
			pinSync_r <= 3'h0;
		end else if (clkEn) begin
			pinMeta_r <= {modeSelectHighPin, modeSelectLowPin, bootSyncPin};
			pinSync_r <= pinMeta_r;
		end
	end

	// function decode of sync, high and low mode pins
	always_comb begin
		func_nxt = FN_NONE;
		case ({pinSync_r[2], pinSync_r[1]})
			2'h3: func_nxt = FN_EPROM_PROGRAM_CONTROL_VERIFY;
			2'h2: func_nxt = FN_VERIFY_ONLY;
			2'h0: func_nxt = FN_DUMP;
			2'h1: func_nxt = pinSync_r[0] ? FN_DRAIN_STRESS
				: FN_GATE_STRESS;
			default: func_nxt = FN_NONE;
		endcase
	end

	// one sample once the synchroniser has filled
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sampleCnt_r <= 2'h0;
			sampled_r <= 1'b0;
			func_r <= FN_NONE;
		end else if (clkEn && !sampled_r) begin
			if (sampleCnt_r != SAMPLE_DELAY) begin
				sampleCnt_r <= sampleCnt_r + 2'h1;
			end else begin
				sampled_r <= 1'b1;
				if (bootMode)
					func_r <= func_nxt;
			end
		end
	end

	// option word taken on the first enabled edge after release
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			opt_r <= OPT_ERASED;
			optDone_r <= 1'b0;
		end else if (clkEn) begin
			if (!optDone_r) begin
				opt_r <= optionWordIn;
				optDone_r <= 1'b1;
			end else if (wrEn && idx == IDX_OPTION && optMapped
				&& testMode && !eprom_program_control_r[EPROM_PROGRAM_CONTROL_LATCH]) begin
				opt_r <= wbDatW[7:0];
			end
		end
	end

	// programming register next value
	always_comb begin
		eprom_program_control_nxt = eprom_program_control_r;
		if (wrEn && idx == IDX_EPROM_PROGRAM_CONTROL) begin
			if (special)
				eprom_program_control_nxt[7:3] = wbDatW[7:3];
			eprom_program_control_nxt[EPROM_PROGRAM_CONTROL_LATCH] = wbDatW[EPROM_PROGRAM_CONTROL_LATCH];
			// power sets only on an already latched register
			if (!wbDatW[EPROM_PROGRAM_CONTROL_POWER])
				eprom_program_control_nxt[EPROM_PROGRAM_CONTROL_POWER] = 1'b0;
			else if (eprom_program_control_r[EPROM_PROGRAM_CONTROL_LATCH])
				eprom_program_control_nxt[EPROM_PROGRAM_CONTROL_POWER] = 1'b1;
		end
		if (!eprom_program_control_nxt[EPROM_PROGRAM_CONTROL_LATCH])
			eprom_program_control_nxt[EPROM_PROGRAM_CONTROL_POWER] = 1'b0;
		// safety cut clears power once the pulse count of enabled cycles reaches the pulse limit
		if (pulseCnt_r >= 32'(PULSE_LIMIT))
			eprom_program_control_nxt[EPROM_PROGRAM_CONTROL_POWER] = 1'b0;
		if (!special)
			eprom_program_control_nxt[7:3] = 5'h00;
		eprom_program_control_nxt[1] = 1'b0;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			eprom_program_control_r <= EPROM_PROGRAM_CONTROL_RESET;
		else if (clkEn)
			eprom_program_control_r <= eprom_program_control_nxt;
	end

	// length of the current programming pulse
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			pulseCnt_r <= 32'h0;
		else if (clkEn) begin
			if (!eprom_program_control_r[EPROM_PROGRAM_CONTROL_POWER])
				pulseCnt_r <= 32'h0;
			else if (pulseCnt_r < 32'(PULSE_LIMIT))
				pulseCnt_r <= pulseCnt_r + 32'h1;
		end
	end

	// loader control, writable only while in boot mode
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			ldr_r <= LDR_RESET;
		else if (clkEn) begin
			ldr_r[LDR_CNT_STEP] <= 1'b0;
			ldr_r[LDR_CNT_RESET] <= 1'b0;
			if (wrEn && idx == IDX_LOADER_CTL && bootMode)
				ldr_r <= wbDatW[7:0];
		end
	end

	// latched programming address and data
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			progAddr <= '0;
			progData <= 8'h00;
		end else if (clkEn && arrayWrStb && eprom_program_control_r[EPROM_PROGRAM_CONTROL_LATCH]) begin
			progAddr <= arrayAddr;
			progData <= arrayWrData;
		end
	end

	// read multiplexer
	always_comb begin
		rdData = 32'h0;
		case (idx)
			IDX_EPROM_PROGRAM_CONTROL: rdData = {24'h0, special ? eprom_program_control_r
				: (eprom_program_control_r & ~EPROM_PROGRAM_CONTROL_SPECIAL_MASK)};
			IDX_OPTION: rdData = optMapped ? {24'h0, opt_r}
				: 32'h0;
			IDX_LOADER_CTL: rdData = {24'h0, ldr_r};
			IDX_LOADER_STAT: rdData = {24'h0, sampled_r, pinSync_r,
				4'(func_r)};
			default: rdData = 32'h0;
		endcase
	end

	// wishbone answer one cycle after the request
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wbAck <= 1'b0;
			wbDatR <= 32'h0;
		end else if (clkEn) begin
			wbAck <= req;
			if (req && !wbWe)
				wbDatR <= rdData;
		end
	end

	// registered pin and array outputs
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			arrayReadEn <= 1'b1;
			progAddrBit4Ignore <= 1'b0;
			programPowerOn <= 1'b0;
			testSelect <= 2'h0;
			programIndicatorPin <= 1'b0;
			programIndicatorOe <= 1'b0;
			verifyIndicatorPin <= 1'b0;
			verifyIndicatorOe <= 1'b0;
			counterClk <= 1'b0;
			counterRst <= 1'b0;
			upperAddrLine <= 1'b0;
		end else if (clkEn) begin
			arrayReadEn <= ~eprom_program_control_r[EPROM_PROGRAM_CONTROL_LATCH];
			progAddrBit4Ignore <= eprom_program_control_r[EPROM_PROGRAM_CONTROL_DUAL_BYTE];
			programPowerOn <= eprom_program_control_r[EPROM_PROGRAM_CONTROL_POWER];
			testSelect <= eprom_program_control_r[EPROM_PROGRAM_CONTROL_TEST_EN]
				? eprom_program_control_r[EPROM_PROGRAM_CONTROL_TSEL_HIGH:EPROM_PROGRAM_CONTROL_TSEL_LOW] : 2'h0;
			programIndicatorOe <= bootMode;
			verifyIndicatorOe <= bootMode;
			programIndicatorPin <= bootMode & ldr_r[LDR_EPROM_PROGRAM_CONTROL_IND];
			verifyIndicatorPin <= bootMode & ldr_r[LDR_VERF_IND];
			counterClk <= bootMode & ldr_r[LDR_CNT_STEP];
			counterRst <= bootMode & ldr_r[LDR_CNT_RESET];
			upperAddrLine <= bootMode & ldr_r[LDR_UPPER_ADDR];
		end
	end

	// option word effects
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			portCPullup <= 8'h00;
			irqEdgeLevel <= 1'b0;
			watchdogEnable <= 1'b0;
		end else if (clkEn) begin
			portCPullup[7:4] <= opt_r[OPT_PULLUP_HI_MSB:OPT_PULLUP_HI_LSB];
			portCPullup[3:2] <= {2{opt_r[OPT_PULLUP_23]}};
			portCPullup[1:0] <= {2{opt_r[OPT_PULLUP_01]}};
			irqEdgeLevel <= opt_r[OPT_IRQ_SENSE];
			// watchdog held off while the loader runs
			watchdogEnable <= opt_r[OPT_WATCHDOG] & ~bootMode;
		end
	end

endmodule : epc_top

//--- core/epc_pkg.sv
// constants for the eprom programming control block
// assumes a 32-bit classic wishbone slave, word per register
package epc_pkg;
	// register indices, byte address is four times the index
	localparam logic [13:0] IDX_EPROM_PROGRAM_CONTROL = 14'h0011;
	localparam logic [13:0] IDX_OPTION = 14'h1f00;
	localparam logic [13:0] IDX_LOADER_CTL = 14'h0020;
	localparam logic [13:0] IDX_LOADER_STAT = 14'h0021;
	// programming control register fields
	localparam int EPROM_PROGRAM_CONTROL_OPT_DECODE = 7;
	localparam int EPROM_PROGRAM_CONTROL_TEST_EN = 6;
	localparam int EPROM_PROGRAM_CONTROL_DUAL_BYTE = 5;
	localparam int EPROM_PROGRAM_CONTROL_TSEL_HIGH = 4;
	localparam int EPROM_PROGRAM_CONTROL_TSEL_LOW = 3;
	localparam int EPROM_PROGRAM_CONTROL_LATCH = 2;
	localparam int EPROM_PROGRAM_CONTROL_POWER = 0;
	localparam logic [7:0] EPROM_PROGRAM_CONTROL_RESET = 8'h00;
	// bits that exist only in boot or test mode
	localparam logic [7:0] EPROM_PROGRAM_CONTROL_SPECIAL_MASK = 8'hf8;
	// option word fields
	localparam int OPT_PULLUP_HI_MSB = 7;
	localparam int OPT_PULLUP_HI_LSB = 4;
	localparam int OPT_PULLUP_23 = 3;
	localparam int OPT_PULLUP_01 = 2;
	localparam int OPT_IRQ_SENSE = 1;
	localparam int OPT_WATCHDOG = 0;
	localparam logic [7:0] OPT_ERASED = 8'h00;
	// loader control register fields
	localparam int LDR_EPROM_PROGRAM_CONTROL_IND = 0;
	localparam int LDR_VERF_IND = 1;
	localparam int LDR_UPPER_ADDR = 2;
	localparam int LDR_CNT_STEP = 3;
	localparam int LDR_CNT_RESET = 4;
	localparam logic [7:0] LDR_RESET = 8'h00;
	// dual-byte programming ignores this address bit
	localparam int DUAL_BYTE_ADDR_BIT = 4;
	// longest programming pulse
	localparam real PULSE_MAX_MS = 10.0;
	localparam real CLK_PERIOD_NS = 10.0;
	localparam int PULSE_MAX_CYCLES = int'(PULSE_MAX_MS * 1.0e6 / CLK_PERIOD_NS);
	// enabled cycles counted after reset before the synchronised pins are read
	localparam logic [1:0] SAMPLE_DELAY = 2'h3;
	typedef enum {
		FN_NONE,
		FN_EPROM_PROGRAM_CONTROL_VERIFY,
		FN_VERIFY_ONLY,
		FN_DUMP,
		FN_GATE_STRESS,
		FN_DRAIN_STRESS
	} epc_function_type;
endpackage : epc_pkg

//--- test/epc_checker_sva.sv
// port checker for the eprom programming control block
// assumes it is bound onto epc_top, one clock domain
`timescale 1ns/1ps
module epc_checker_sva
	import epc_pkg::*;
#(
	parameter int ARRAY_AW = 13
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbAck,
	input wire logic bootMode,
	input wire logic arrayWrStb,
	input wire logic [ARRAY_AW-1:0] arrayAddr,
	input wire logic [7:0] arrayWrData,
	input wire logic arrayReadEn,
	input wire logic [ARRAY_AW-1:0] progAddr,
	input wire logic [7:0] progData,
	input wire logic programPowerOn,
	input wire logic programIndicatorOe,
	input wire logic verifyIndicatorOe,
	input wire logic counterClk,
	input wire logic [7:0] portCPullup,
	input wire logic watchdogEnable
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_ack_follows: assert property (wbCyc && wbStb && !wbAck && clkEn |=> wbAck)
		else $error("no ack after request");
	a_ack_single: assert property (wbAck && clkEn |=> !wbAck)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(wbAck) |-> $past(wbCyc && wbStb))
		else $error("ack without request");
	a_power_latch: assert property ($rose(programPowerOn) |-> $past(!arrayReadEn))
		else $error("power set without latch");
	a_power_clear: assert property (arrayReadEn && $past(arrayReadEn) |-> !programPowerOn)
		else $error("power kept with latch clear");
	a_latch_capture: assert property (arrayWrStb && !arrayReadEn |=>
		progAddr == $past(arrayAddr) && progData == $past(arrayWrData))
		else $error("latched write not captured");
	a_pullup_pairs: assert property (portCPullup[3] == portCPullup[2] &&
		portCPullup[1] == portCPullup[0]) else $error("pullup pair split");
	a_wdog_boot: assert property ($past(resetn) && $past(bootMode) |-> !watchdogEnable)
		else $error("watchdog on in boot mode");
	a_ind_enable: assert property ($past(resetn) && $past(bootMode) |->
		programIndicatorOe && verifyIndicatorOe) else $error("indicator not driven");
	a_cnt_pulse: assert property (counterClk |=> !counterClk)
		else $error("counter clock pulse too long");
endmodule : epc_checker_sva
bind epc_top epc_checker_sva #(.ARRAY_AW(ARRAY_AW)) chk_u (.*);

//--- test/epc_source_model.sv
// source memory model: external 12-bit counter and the code bytes
// assumes counter pulses last one core clock
`timescale 1ns/1ps
module epc_source_model (
	input wire logic core_clk,
	input wire logic counterClk,
	input wire logic counterRst,
	input wire logic upperAddrLine,
	output logic [7:0] srcByte
);
	logic [11:0] srcCnt_r;
	always_ff @(posedge core_clk) begin
		if (counterRst) begin
			srcCnt_r <= 12'h000;
		end else if (counterClk) begin
			srcCnt_r <= srcCnt_r + 12'h001;
		end
	end
	// byte depends on the upper line too
	assign srcByte = {upperAddrLine, srcCnt_r[6:0]} ^ 8'h5a;
endmodule : epc_source_model

//--- test/eprom_program_control_bench.sv
// self-checking bench for epc_top with a source memory model
// assumes the package, checker and model are compiled first
`timescale 1ns/1ps
module eprom_program_control_bench;
	import epc_pkg::*;
	logic core_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, testMode = 1'b0;
	logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, ioDecodeOff = 1'b0;
	logic [15:0] wbAdr = 16'h0000;
	logic [3:0] wbSel = 4'h1;
	logic [31:0] wbDatW = 32'h00000000, wbDatR;
	logic bootMode = 1'b1, bootSyncPin = 1'b0, arrayWrStb = 1'b0;
	logic modeSelectLowPin = 1'b0, modeSelectHighPin = 1'b0;
	logic [7:0] optionWordIn = 8'h00, arrayWrData = 8'h00, progData;
	logic [12:0] arrayAddr = 13'h0000, progAddr;
	logic wbAck, arrayReadEn, progAddrBit4Ignore, programPowerOn;
	logic programIndicatorPin, programIndicatorOe, verifyIndicatorPin;
	logic verifyIndicatorOe, counterClk, counterRst, upperAddrLine;
	logic irqEdgeLevel, watchdogEnable;
	logic [1:0] testSelect;
	logic [7:0] portCPullup, srcByte, rdat;
	logic [2:0] modes [5] = '{3'h6, 3'h4, 3'h0, 3'h2, 3'h3};
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;
	epc_top #(.PULSE_LIMIT(50)) dut_u (.*);
	epc_source_model src_u (.*);
	initial forever #5 core_clk = ~core_clk;
	task automatic print_verdict();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic acc(input logic [13:0] idx, logic we, logic [7:0] d);
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'b00};
		wbDatW <= {24'h000000, d};
		do @(posedge core_clk); while (wbAck !== 1'b1);
		rdat = wbDatR[7:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask : acc
	task automatic rd(input string what, logic [13:0] idx, logic [7:0] e);
		acc(idx, 1'b0, 8'h00);
		chk(what, e, rdat);
	endtask : rd
	task automatic rst(input logic b, logic [7:0] o, logic [2:0] p);
		@(posedge core_clk);
		resetn <= 1'b0;
		bootMode <= b;
		optionWordIn <= o;
		{modeSelectHighPin, modeSelectLowPin, bootSyncPin} <= p;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (12) @(posedge core_clk);
	endtask : rst
	task automatic aw(input logic [12:0] a);
		repeat (3) @(posedge core_clk);
		arrayWrStb <= 1'b1;
		arrayAddr <= a;
		arrayWrData <= srcByte;
		@(posedge core_clk);
		arrayWrStb <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : aw
	initial begin
		for (int i = 0; i < 5; i++) begin
			rst(1'b1, 8'h00, modes[i]);
			rd("status", IDX_LOADER_STAT, {1'b1, modes[i], 4'(i + 1)});
			chk("pullup", 8'h00, portCPullup);
		end
		{modeSelectHighPin, modeSelectLowPin, bootSyncPin} <= 3'h6;
		repeat (8) @(posedge core_clk);
		acc(IDX_LOADER_STAT, 1'b0, 8'h00);
		chk("function", 8'h05, {4'h0, rdat[3:0]});
		rst(1'b1, 8'ha5, 3'h6);
		chk("pullup", 8'ha3, portCPullup);
		chk("irq", 8'h00, irqEdgeLevel);
		chk("wdog", 8'h00, watchdogEnable);
		rd("eprom_program_control", IDX_EPROM_PROGRAM_CONTROL, 8'h00);
		acc(IDX_EPROM_PROGRAM_CONTROL, 1'b1, 8'hff);
		rd("eprom_program_control", IDX_EPROM_PROGRAM_CONTROL, 8'hfc);
		chk("tsel", 8'h03, testSelect);
		chk("dual", 8'h01, progAddrBit4Ignore);
		chk("rden", 8'h00, arrayReadEn);
		acc(IDX_LOADER_CTL, 1'b1, 8'h14);
		repeat (3) acc(IDX_LOADER_CTL, 1'b1, 8'h0f);
		chk("ind", 8'h03, {programIndicatorPin, verifyIndicatorPin});
		chk("upper", 8'h01, upperAddrLine);
		aw(13'h0b35);
		chk("paddr", 8'h35, progAddr[7:0]);
		chk("pdata", 8'hd9, progData);
		acc(IDX_EPROM_PROGRAM_CONTROL, 1'b1, 8'h07);
		rd("eprom_program_control", IDX_EPROM_PROGRAM_CONTROL, 8'h05);
		chk("power", 8'h01, programPowerOn);
		clkEn <= 1'b0;
		repeat (100) @(posedge core_clk);
		clkEn <= 1'b1;
		chk("frozen", 8'h01, programPowerOn);
		repeat (60) @(posedge core_clk);
		rd("eprom_program_control", IDX_EPROM_PROGRAM_CONTROL, 8'h04);
		acc(IDX_EPROM_PROGRAM_CONTROL, 1'b1, 8'h18);
		repeat (2) @(posedge core_clk);
		chk("tsel", 8'h00, testSelect);
		chk("rden", 8'h01, arrayReadEn);
		aw(13'h0777);
		chk("paddr", 8'h35, progAddr[7:0]);
		acc(IDX_EPROM_PROGRAM_CONTROL, 1'b1, 8'h80);
		rd("option", IDX_OPTION, 8'ha5);
		ioDecodeOff <= 1'b1;
		rd("option", IDX_OPTION, 8'h00);
		ioDecodeOff <= 1'b0;
		acc(IDX_EPROM_PROGRAM_CONTROL, 1'b1, 8'h00);
		rd("option", IDX_OPTION, 8'h00);
		rd("unmapped", 14'h03ff, 8'h00);
		rst(1'b0, 8'h4b, 3'h0);
		acc(IDX_EPROM_PROGRAM_CONTROL, 1'b1, 8'hff);
		rd("eprom_program_control", IDX_EPROM_PROGRAM_CONTROL, 8'h04);
		chk("pullup", 8'h4c, portCPullup);
		chk("irq", 8'h01, irqEdgeLevel);
		chk("wdog", 8'h01, watchdogEnable);
		chk("oe", 8'h00, {programIndicatorOe, verifyIndicatorOe});
		testMode <= 1'b1;
		acc(IDX_EPROM_PROGRAM_CONTROL, 1'b1, 8'h80);
		acc(IDX_OPTION, 1'b1, 8'h3c);
		rd("option", IDX_OPTION, 8'h3c);
		print_verdict();
	end
endmodule : eprom_program_control_bench
